// ---- core/clock_source_select_pkg.sv ----
// Constants and types shared by the clock source selection block
package clock_source_select_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PROCESSOR_AND_REFERENCE = 8'h0D; // Processor source and PLL reference
	localparam logic [7:0] IDX_DAC_AND_OVERSAMPLE = 8'h0E; // Converter and oversampling sources
	localparam logic [7:0] IDX_CHARGE_PUMP = 8'h0F; // Charge-pump source
	localparam logic [7:0] IDX_ROUTE_DSP_DAC = 8'h10; // Pin route, processor and converter
	localparam logic [7:0] IDX_ROUTE_PUMP_OVERSAMPLE = 8'h11; // Pin route, pump and oversampling
	localparam logic [7:0] IDX_ROUTE_PLL_REFERENCE = 8'h12; // Pin route, PLL reference
	localparam logic [7:0] IDX_MUTE_STATUS = 8'h13; // Read-only mute status

	// Field positions inside an 8-bit register
	localparam int FIELD_HI_LSB = 4; // Upper field, bits 6-4
	localparam int FIELD_LO_LSB = 0; // Lower field, bits 2-0
	localparam int FIELD_W = 3; // Every selection field is three bits

	// Reset value of every selection field
	localparam logic [2:0] SEL_RESET = 3'h0;

	// Converter and processor divider source codes
	localparam logic [2:0] DAC_MASTER = 3'h0;
	localparam logic [2:0] DAC_PLL = 3'h1;
	localparam logic [2:0] DAC_OSC = 3'h2;
	localparam logic [2:0] DAC_MCLK = 3'h3;
	localparam logic [2:0] DAC_BCLK = 3'h4;
	localparam logic [2:0] DAC_GPIO = 3'h5;

	// Oversampling and charge-pump divider source codes
	localparam logic [2:0] OSR_DAC = 3'h0;
	localparam logic [2:0] OSR_MASTER = 3'h1;
	localparam logic [2:0] OSR_PLL = 3'h2;
	localparam logic [2:0] OSR_OSC = 3'h3;
	localparam logic [2:0] OSR_MCLK = 3'h4;
	localparam logic [2:0] OSR_BCLK = 3'h5;
	localparam logic [2:0] OSR_GPIO = 3'h6;

	// PLL reference source codes
	localparam logic [2:0] REF_MCLK = 3'h0;
	localparam logic [2:0] REF_BCLK = 3'h1;
	localparam logic [2:0] REF_OSC = 3'h2;
	localparam logic [2:0] REF_GPIO = 3'h3;

	// Pin route code that takes the serial data output pin
	localparam logic [2:0] ROUTE_SERIAL_DATA_OUT_PIN = 3'h5;

	// Constant level of a muted clock
	localparam logic MUTE_LEVEL = 1'b0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register decode result
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_PROC_REF,
		SEL_DAC_OSR,
		SEL_PUMP,
		SEL_ROUTE_DD,
		SEL_ROUTE_PO,
		SEL_ROUTE_REF,
		SEL_STATUS
	} reg_sel_e;

endpackage : clock_source_select_pkg

// ---- core/clock_source_select_mux.sv ----
// Register-controlled clock source selection for the internal divider chains
`timescale 1ns/10ps
module clock_source_select_mux (
	input wire logic clk, // System clock, 100 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic clock_auto_set_mode, // Auto-set mode active
	input wire logic master_auto_clk, // Master clock after auto-select
	input wire logic pll_clk, // PLL output clock
	input wire logic internal_oscillator, // Internal oscillator clock
	input wire logic master_in_clk, // Master clock input pin
	input wire logic bit_clk, // Serial bit clock pin
	input wire logic serial_data_out_pin, // Serial data output pin as input
	output logic dac_divider_clk, // Converter divider input
	output logic oversample_divider_clk, // Oversampling divider input
	output logic pump_divider_clk, // Charge-pump divider input
	output logic processor_divider_clk, // Processor divider input
	output logic pll_reference_clk // PLL reference input
);
	import clock_source_select_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	// Whole block state
	typedef struct packed {
		logic [2:0] dac_divider_source_select; // Converter source
		logic [2:0] oversample_divider_source_select; // Oversampling source
		logic [2:0] charge_pump_divider_source_select; // Pump source
		logic [2:0] processor_divider_source_select; // Processor source
		logic [2:0] pll_reference_source_select; // Reference source
		logic [2:0] pin_route_for_processor_clock; // Processor pin route
		logic [2:0] pin_route_for_converter_clock; // Converter pin route
		logic [2:0] pin_route_for_pump_clock; // Pump pin route
		logic [2:0] pin_route_for_oversample_clock; // Oversampling pin route
		logic [2:0] pin_route_for_pll_reference; // Reference pin route
		logic aw_got; // Write address held
		logic w_got; // Write data held
		logic [7:0] awaddr; // Held write address
		logic [7:0] wdata; // Held low data byte
		logic wstrb0; // Held low byte strobe
		logic bvalid; // Write response pending
		logic [1:0] bresp; // Write response code
		logic rvalid; // Read data pending
		logic [31:0] rdata; // Read data
		logic [1:0] rresp; // Read response code
	} state_s;

	state_s state_reg; // Registered state
	state_s state_next; // Next state

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Map a byte address to a register
	function automatic reg_sel_e decode(input logic [7:0] addr);
		reg_sel_e sel;
		sel = SEL_NONE;
		if (addr[1:0] == 2'h0) begin
			case (addr[7:2])
				IDX_PROCESSOR_AND_REFERENCE[5:0]: sel = SEL_PROC_REF;
				IDX_DAC_AND_OVERSAMPLE[5:0]: sel = SEL_DAC_OSR;
				IDX_CHARGE_PUMP[5:0]: sel = SEL_PUMP;
				IDX_ROUTE_DSP_DAC[5:0]: sel = SEL_ROUTE_DD;
				IDX_ROUTE_PUMP_OVERSAMPLE[5:0]: sel = SEL_ROUTE_PO;
				IDX_ROUTE_PLL_REFERENCE[5:0]: sel = SEL_ROUTE_REF;
				IDX_MUTE_STATUS[5:0]: sel = SEL_STATUS;
				default: sel = SEL_NONE;
			endcase
		end
		return sel;
	endfunction : decode

	// Pin route: only the serial-out code passes a clock
	function automatic logic pin_route(input logic [2:0] route, input logic pin);
		return (route == ROUTE_SERIAL_DATA_OUT_PIN) ? pin : MUTE_LEVEL;
	endfunction : pin_route

	// Converter and processor style selection
	function automatic logic dac_style(input logic [2:0] sel, input logic gpio);
		logic c;
		case (sel)
			DAC_MASTER: c = master_auto_clk;
			DAC_PLL: c = pll_clk;
			DAC_OSC: c = internal_oscillator;
			DAC_MCLK: c = master_in_clk;
			DAC_BCLK: c = bit_clk;
			DAC_GPIO: c = gpio;
			default: c = MUTE_LEVEL;
		endcase
		return c;
	endfunction : dac_style

	// Oversampling and pump style selection
	function automatic logic osr_style(input logic [2:0] sel, input logic dac, input logic gpio);
		logic c;
		case (sel)
			OSR_DAC: c = dac;
			OSR_MASTER: c = master_auto_clk;
			OSR_PLL: c = pll_clk;
			OSR_OSC: c = internal_oscillator;
			OSR_MCLK: c = master_in_clk;
			OSR_BCLK: c = bit_clk;
			OSR_GPIO: c = gpio;
			default: c = MUTE_LEVEL;
		endcase
		return c;
	endfunction : osr_style

	// Place two fields in a register image
	function automatic logic [31:0] pack2(input logic [2:0] hi, input logic [2:0] lo);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[FIELD_HI_LSB +: FIELD_W] = hi;
		v[FIELD_LO_LSB +: FIELD_W] = lo;
		return v;
	endfunction : pack2

	////////////////////////////////////////////////////////////////////////////////
	// Clock selection

	logic ref_gpio; // Reference pin route result
	logic [2:0] ref_effective; // Reference code after auto-set override
	logic [4:0] mute_flags; // One bit per output, high when its own code and route mute it

	// Divider input muxes
	always_comb begin
		dac_divider_clk = dac_style(state_reg.dac_divider_source_select,
			pin_route(state_reg.pin_route_for_converter_clock, serial_data_out_pin));
		processor_divider_clk = dac_style(state_reg.processor_divider_source_select,
			pin_route(state_reg.pin_route_for_processor_clock, serial_data_out_pin));
		oversample_divider_clk = osr_style(state_reg.oversample_divider_source_select, dac_divider_clk,
			pin_route(state_reg.pin_route_for_oversample_clock, serial_data_out_pin));
		pump_divider_clk = osr_style(state_reg.charge_pump_divider_source_select, dac_divider_clk,
			pin_route(state_reg.pin_route_for_pump_clock, serial_data_out_pin));
	end

	// PLL reference mux, auto-set forces the master input
	always_comb begin
		ref_gpio = pin_route(state_reg.pin_route_for_pll_reference, serial_data_out_pin);
		ref_effective = clock_auto_set_mode ? REF_MCLK : state_reg.pll_reference_source_select;
		case (ref_effective)
			REF_MCLK: pll_reference_clk = master_in_clk;
			REF_BCLK: pll_reference_clk = bit_clk;
			REF_OSC: pll_reference_clk = internal_oscillator;
			REF_GPIO: pll_reference_clk = ref_gpio;
			default: pll_reference_clk = MUTE_LEVEL;
		endcase
	end

	// Mute status seen by software
	always_comb begin
		mute_flags[0] = (state_reg.dac_divider_source_select > DAC_GPIO) ||
			(state_reg.dac_divider_source_select == DAC_GPIO && state_reg.pin_route_for_converter_clock != ROUTE_SERIAL_DATA_OUT_PIN);
		mute_flags[1] = (state_reg.oversample_divider_source_select > OSR_GPIO) ||
			(state_reg.oversample_divider_source_select == OSR_GPIO &&
			state_reg.pin_route_for_oversample_clock != ROUTE_SERIAL_DATA_OUT_PIN);
		mute_flags[2] = (state_reg.charge_pump_divider_source_select > OSR_GPIO) ||
			(state_reg.charge_pump_divider_source_select == OSR_GPIO &&
			state_reg.pin_route_for_pump_clock != ROUTE_SERIAL_DATA_OUT_PIN);
		mute_flags[3] = (state_reg.processor_divider_source_select > DAC_GPIO) ||
			(state_reg.processor_divider_source_select == DAC_GPIO &&
			state_reg.pin_route_for_processor_clock != ROUTE_SERIAL_DATA_OUT_PIN);
		mute_flags[4] = (ref_effective > REF_GPIO) ||
			(ref_effective == REF_GPIO && state_reg.pin_route_for_pll_reference != ROUTE_SERIAL_DATA_OUT_PIN);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshakes

	// Ready terms from held state
	always_comb begin
		s_axi_awready = !state_reg.aw_got && !state_reg.bvalid; // Address slot free
		s_axi_wready = !state_reg.w_got && !state_reg.bvalid; // Data slot free
		s_axi_arready = !state_reg.rvalid; // One read at a time
		s_axi_bvalid = state_reg.bvalid;
		s_axi_bresp = state_reg.bresp;
		s_axi_rvalid = state_reg.rvalid;
		s_axi_rdata = state_reg.rdata;
		s_axi_rresp = state_reg.rresp;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	// Register writes, reads and responses
	always_comb begin
		reg_sel_e wsel;
		reg_sel_e rsel;
		logic [2:0] hi;
		logic [2:0] lo;
		wsel = SEL_NONE;
		rsel = SEL_NONE;
		state_next = state_reg;
		hi = state_reg.wdata[FIELD_HI_LSB +: FIELD_W];
		lo = state_reg.wdata[FIELD_LO_LSB +: FIELD_W];
		// Capture write address
		if (s_axi_awvalid && s_axi_awready) begin
			state_next.aw_got = 1'b1;
			state_next.awaddr = s_axi_awaddr;
		end
		// Capture write data
		if (s_axi_wvalid && s_axi_wready) begin
			state_next.w_got = 1'b1;
			state_next.wdata = s_axi_wdata[7:0];
			state_next.wstrb0 = s_axi_wstrb[0];
		end
		// Commit once both halves are held
		if (state_reg.aw_got && state_reg.w_got) begin
			wsel = decode(state_reg.awaddr);
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = RESP_OKAY;
			if (state_reg.wstrb0) begin
				case (wsel)
					SEL_PROC_REF: begin
						state_next.pll_reference_source_select = hi;
						state_next.processor_divider_source_select = lo;
					end
					SEL_DAC_OSR: begin
						state_next.dac_divider_source_select = hi;
						state_next.oversample_divider_source_select = lo;
					end
					SEL_PUMP: state_next.charge_pump_divider_source_select = lo;
					SEL_ROUTE_DD: begin
						state_next.pin_route_for_processor_clock = hi;
						state_next.pin_route_for_converter_clock = lo;
					end
					SEL_ROUTE_PO: begin
						state_next.pin_route_for_pump_clock = hi;
						state_next.pin_route_for_oversample_clock = lo;
					end
					SEL_ROUTE_REF: state_next.pin_route_for_pll_reference = lo;
					default: begin
					end
				endcase
			end
			// Status is read-only; unmapped gets an error
			if (wsel == SEL_NONE || wsel == SEL_STATUS) begin
				state_next.bresp = RESP_SLVERR;
			end
		end
		// Write response taken
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		// Read response taken
		if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		// Read address taken, data ready next cycle
		if (s_axi_arvalid && s_axi_arready) begin
			rsel = decode(s_axi_araddr);
			state_next.rvalid = 1'b1;
			state_next.rresp = RESP_OKAY;
			case (rsel)
				SEL_PROC_REF: state_next.rdata = pack2(state_reg.pll_reference_source_select,
					state_reg.processor_divider_source_select);
				SEL_DAC_OSR: state_next.rdata = pack2(state_reg.dac_divider_source_select,
					state_reg.oversample_divider_source_select);
				SEL_PUMP: state_next.rdata = pack2(3'h0, state_reg.charge_pump_divider_source_select);
				SEL_ROUTE_DD: state_next.rdata = pack2(state_reg.pin_route_for_processor_clock,
					state_reg.pin_route_for_converter_clock);
				SEL_ROUTE_PO: state_next.rdata = pack2(state_reg.pin_route_for_pump_clock,
					state_reg.pin_route_for_oversample_clock);
				SEL_ROUTE_REF: state_next.rdata = pack2(3'h0, state_reg.pin_route_for_pll_reference);
				SEL_STATUS: state_next.rdata = {27'h0, mute_flags};
				default: begin
					state_next.rdata = 32'h0000_0000;
					state_next.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	// Clear everything on reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.dac_divider_source_select <= SEL_RESET;
			state_reg.oversample_divider_source_select <= SEL_RESET;
			state_reg.charge_pump_divider_source_select <= SEL_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : clock_source_select_mux

// ---- test/clock_source_select_sva.sv ----
// Port checks for the clock source selection block
`timescale 1ns/10ps
module clock_source_select_sva (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic [1:0] s_axi_bresp, // B resp
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_bready, // B ready
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic [31:0] s_axi_rdata, // R data
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic master_auto_clk, // Source
	input wire logic master_in_clk, // Source
	input wire logic dac_divider_clk, // Output
	input wire logic oversample_divider_clk, // Output
	input wire logic pump_divider_clk, // Output
	input wire logic processor_divider_clk, // Output
	input wire logic pll_reference_clk // Output
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Both write halves taken at one edge
	sequence both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Response two edges after the take
	sequence resp_two_later;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	AST_WRITE_LATENCY: assert property (both_taken |=> resp_two_later)
		else $error("write response late or early");
	AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_WRITE_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while responding");
	AST_READ_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after address");
	AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_READ_CAUSE: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
		else $error("read data without address");
	AST_READ_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answering");
	AST_RESET_SOURCES: assert property ($fell(rst) |-> dac_divider_clk == master_auto_clk
		&& oversample_divider_clk == dac_divider_clk && pump_divider_clk == dac_divider_clk
		&& processor_divider_clk == master_auto_clk && pll_reference_clk == master_in_clk)
		else $error("sources after reset wrong");
endmodule : clock_source_select_sva
bind clock_source_select_mux clock_source_select_sva u_sva (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .master_auto_clk, .master_in_clk, .dac_divider_clk,
	.oversample_divider_clk, .pump_divider_clk, .processor_divider_clk, .pll_reference_clk);

// ---- test/clock_source_select_mux_tb.sv ----
// Self-checking bench for the clock source selection block
`timescale 1ns/10ps
module clock_source_select_mux_tb;
	import clock_source_select_pkg::*;
	logic clk = 1'b0, rst = 1'b1, clock_auto_set_mode = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0, cnt = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic master_auto_clk, pll_clk, internal_oscillator, master_in_clk, bit_clk, serial_data_out_pin;
	logic dac_divider_clk, oversample_divider_clk, pump_divider_clk, processor_divider_clk, pll_reference_clk;
	logic [7:0] sh [0:5]; // Expected register contents
	int fails = 0, num_checks = 0;
	////////////////////////////////////////////////////////////////
	always #5 clk = ~clk;
	// Distinct source patterns from one counter
	always @(posedge clk) cnt <= cnt + 4'h1;
	assign master_auto_clk = cnt[0];
	assign pll_clk = cnt[1];
	assign internal_oscillator = cnt[2];
	assign master_in_clk = cnt[3];
	assign bit_clk = cnt[0] ^ cnt[1];
	assign serial_data_out_pin = cnt[1] ^ cnt[2] ^ cnt[3];
	clock_source_select_mux dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.clock_auto_set_mode, .master_auto_clk, .pll_clk, .internal_oscillator, .master_in_clk, .bit_clk,
		.serial_data_out_pin, .dac_divider_clk, .oversample_divider_clk, .pump_divider_clk,
		.processor_divider_clk, .pll_reference_clk);
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic hang();
		fails++;
		$display("unexpected handshake expected answer seen none");
		end_sim();
	endtask : hang
	// Write one register; bready stands high from the start until bvalid is seen
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
		logic ah, wh, bv, bh;
		logic [1:0] r;
		bh = 1'b0;
		r = 2'h3;
		s_axi_awaddr <= {idx[5:0], 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int k = 0; k < 40 && !bh; k++) begin
			@(negedge clk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bv = s_axi_bvalid;
			bh = bv && s_axi_bready;
			r = s_axi_bresp;
			@(posedge clk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		if (!bh) hang();
		cmp("bresp", {30'h0, er}, {30'h0, r});
	endtask : wr
	// Read one register; rready stands high from the start until rvalid is seen
	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		logic ah, rv, rh;
		rh = 1'b0;
		s_axi_araddr <= {idx[5:0], 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int k = 0; k < 40 && !rh; k++) begin
			@(negedge clk);
			ah = s_axi_arvalid && s_axi_arready;
			rv = s_axi_rvalid;
			rh = rv && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ah) s_axi_arvalid <= 1'b0;
		end
		if (!rh) hang();
	endtask : rd
	task automatic rb(input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(idx, d, r);
		cmp("rdata", {24'h0, e}, d);
		cmp("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask : rb
	// Store with reserved bits set; they must read back as zero
	task automatic sr(input logic [7:0] idx, input logic [7:0] v);
		sh[idx - 8'h0D] = v & ((idx == IDX_CHARGE_PUMP || idx == IDX_ROUTE_PLL_REFERENCE) ? 8'h07 : 8'h77);
		wr(idx, v | 8'h88, 4'hF, RESP_OKAY);
	endtask : sr
	////////////////////////////////////////////////////////////////
	// Source for converter-style codes, pin gated by its route
	function automatic logic pick(input logic [2:0] c, input logic [2:0] rt);
		case (c)
			DAC_MASTER: return master_auto_clk;
			DAC_PLL: return pll_clk;
			DAC_OSC: return internal_oscillator;
			DAC_MCLK: return master_in_clk;
			DAC_BCLK: return bit_clk;
			DAC_GPIO: return (rt == 3'h5) ? serial_data_out_pin : 1'b0;
			default: return 1'b0;
		endcase
	endfunction : pick
	function automatic logic [4:0] expv();
		logic d, o, p, q, r;
		logic [2:0] rc;
		d = pick(sh[1][6:4], sh[3][2:0]);
		o = (sh[1][2:0] == 3'h0) ? d : (sh[1][2:0] == 3'h7) ? 1'b0 : pick(sh[1][2:0] - 3'h1, sh[4][2:0]);
		p = (sh[2][2:0] == 3'h0) ? d : (sh[2][2:0] == 3'h7) ? 1'b0 : pick(sh[2][2:0] - 3'h1, sh[4][6:4]);
		q = pick(sh[0][2:0], sh[3][6:4]);
		rc = clock_auto_set_mode ? 3'h0 : sh[0][6:4];
		r = (rc == 3'h0) ? master_in_clk : (rc == 3'h1) ? bit_clk : (rc == 3'h2) ? internal_oscillator :
			(rc == 3'h3 && sh[5][2:0] == 3'h5) ? serial_data_out_pin : 1'b0;
		return {d, o, p, q, r};
	endfunction : expv
	// Compare all five clock outputs over a full source period
	task automatic ck();
		for (int i = 0; i < 16; i++) begin
			@(negedge clk);
			cmp("clocks", {27'h0, expv()}, {27'h0, dac_divider_clk, oversample_divider_clk, pump_divider_clk,
				processor_divider_clk, pll_reference_clk});
		end
		@(posedge clk);
	endtask : ck
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 7; i++) rb(8'h0D + i[7:0], 8'h00);
		ck();
		$display("test reset done");
	endtask : t_reset
	task automatic t_bus();
		logic [31:0] d;
		logic [1:0] r;
		sr(IDX_DAC_AND_OVERSAMPLE, 8'h21);
		rb(IDX_DAC_AND_OVERSAMPLE, 8'h21);
		wr(IDX_DAC_AND_OVERSAMPLE, 8'h44, 4'h0, RESP_OKAY);
		rb(IDX_DAC_AND_OVERSAMPLE, 8'h21);
		wr(IDX_MUTE_STATUS, 8'hFF, 4'hF, RESP_SLVERR);
		wr(8'h20, 8'h11, 4'hF, RESP_SLVERR);
		rd(8'h20, d, r);
		cmp("rdata", 32'h0, d);
		cmp("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		ck();
		$display("test bus done");
	endtask : t_bus
	task automatic t_dac();
		sr(IDX_ROUTE_DSP_DAC, 8'h05);
		for (int c = 0; c < 8; c++) begin
			sr(IDX_DAC_AND_OVERSAMPLE, {1'b0, c[2:0], 4'h0});
			ck();
		end
		$display("test converter done");
	endtask : t_dac
	task automatic t_osr();
		sr(IDX_ROUTE_PUMP_OVERSAMPLE, 8'h55);
		for (int c = 0; c < 8; c++) begin
			sr(IDX_DAC_AND_OVERSAMPLE, {5'h02, c[2:0]});
			sr(IDX_CHARGE_PUMP, {5'h0, c[2:0]});
			rb(IDX_CHARGE_PUMP, {5'h0, c[2:0]});
			ck();
		end
		$display("test oversample done");
	endtask : t_osr
	task automatic t_proc();
		sr(IDX_ROUTE_DSP_DAC, 8'h55);
		sr(IDX_ROUTE_PLL_REFERENCE, 8'h05);
		for (int c = 0; c < 8; c++) begin
			sr(IDX_PROCESSOR_AND_REFERENCE, {1'b0, c[2:0], 1'b0, c[2:0]});
			ck();
		end
		clock_auto_set_mode <= 1'b1;
		ck();
		rb(IDX_PROCESSOR_AND_REFERENCE, 8'h77);
		clock_auto_set_mode <= 1'b0;
		$display("test processor done");
	endtask : t_proc
	task automatic t_route();
		sr(IDX_PROCESSOR_AND_REFERENCE, 8'h35);
		sr(IDX_DAC_AND_OVERSAMPLE, 8'h56);
		sr(IDX_CHARGE_PUMP, 8'h06);
		for (int r = 0; r < 8; r++) begin
			sr(IDX_ROUTE_DSP_DAC, {1'b0, r[2:0], 1'b0, r[2:0]});
			sr(IDX_ROUTE_PUMP_OVERSAMPLE, {1'b0, r[2:0], 1'b0, r[2:0]});
			sr(IDX_ROUTE_PLL_REFERENCE, {5'h0, r[2:0]});
			ck();
			rb(IDX_MUTE_STATUS, (r == 5) ? 8'h00 : 8'h1F);
		end
		$display("test pin routes done");
	endtask : t_route
	////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 6; i++) sh[i] = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_bus();
		t_dac();
		t_osr();
		t_proc();
		t_route();
		end_sim();
	end
endmodule : clock_source_select_mux_tb
